// >>> rtl/lpsc_top.sv
`timescale 1ns/10ps
`include "lpsc_defines.svh"

module lpsc_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        REG_WE,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        LASER_DRIVE_PIN_IN,
  output logic             LASER_DRIVE_PIN_OUT,
  output logic             LASER_DRIVE_PIN_OE,
  output logic             LASER_DRIVE_EN,
  output logic      [1:0]  LASER_RANGE,
  output logic      [7:0]  LASER_CURRENT,
  output logic             LASER_SUPPLY_SWITCH_N,
  output logic             LASER_FAULT
);

  lpsc_pkg::lpsc_wr_t    wr;
  lpsc_pkg::lpsc_drive_t drive_nxt;
  logic [7:0] ctrl_first_r;
  logic [7:0] ctrl_second_r;
  logic [7:0] cfg_first_r;
  logic [7:0] cfg_second_r;
  logic [7:0] cur_applied_r;
  logic [7:0] pulse_cnt_r;
  logic       pin_meta_r;
  logic       pin_sync_r;
  logic       fault_r;
  logic       cal_mode;
  logic       pulse_on;
  logic       test_active;
  logic       test_fail;
  logic       ground_fault;
  logic [7:0] cfg_first_nxt;
  logic [7:0] cfg_second_nxt;
  logic [`LPSC_BLANK_LEN-1:0] test_hist_r;
  logic       test_blank;
  logic       fault_any;

  assign wr = '{we: REG_WE, addr: REG_ADDR, wdata: REG_WDATA};

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_first_r  <= `LPSC_REG_RESET;
      ctrl_second_r <= `LPSC_REG_RESET;
      cfg_first_r   <= `LPSC_REG_RESET;
      cfg_second_r  <= `LPSC_REG_RESET;
    end else if (wr.we) begin
      if (wr.addr == `LPSC_ADDR_CTRL_FIRST) begin
        ctrl_first_r <= wr.wdata;
      end else if (wr.addr == `LPSC_ADDR_CFG_FIRST) begin
        cfg_first_r <= wr.wdata;
      end else if (wr.addr == `LPSC_ADDR_CFG_SECOND) begin
        cfg_second_r <= wr.wdata;
      end else if (wr.addr == `LPSC_ADDR_CTRL_SECOND) begin
        ctrl_second_r <= wr.wdata;
      end
    end
  end

  // Read data also shows the latched fault in ctrl_first bit 0
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_ADDR == `LPSC_ADDR_CTRL_FIRST) begin
      REG_RDATA <= {ctrl_first_r[7:1], fault_r};
    end else if (REG_ADDR == `LPSC_ADDR_CFG_FIRST) begin
      REG_RDATA <= cfg_first_r;
    end else if (REG_ADDR == `LPSC_ADDR_CFG_SECOND) begin
      REG_RDATA <= cfg_second_r;
    end else if (REG_ADDR == `LPSC_ADDR_CTRL_SECOND) begin
      REG_RDATA <= ctrl_second_r;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Current setting
  // ----------------------------------------------------------------
  // Compare against post-write values so either byte order works
  always_comb begin
    cfg_first_nxt  = cfg_first_r;
    cfg_second_nxt = cfg_second_r;
    if (wr.we && wr.addr == `LPSC_ADDR_CFG_FIRST) begin
      cfg_first_nxt = wr.wdata;
    end
    if (wr.we && wr.addr == `LPSC_ADDR_CFG_SECOND) begin
      cfg_second_nxt = wr.wdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_applied_r <= `LPSC_CUR_MIN;
    end else if (cfg_first_nxt == ~cfg_second_nxt) begin
      cur_applied_r <= cfg_first_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Drive mode
  // ----------------------------------------------------------------
  // all three bits select continuous
  assign cal_mode = (ctrl_first_r[`LPSC_CAL_HI:`LPSC_CAL_LO] == `LPSC_CAL_ALL);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pulse_cnt_r <= 8'h00;
    end else if (pulse_cnt_r == `LPSC_PULSE_PERIOD) begin
      pulse_cnt_r <= 8'h00;
    end else begin
      pulse_cnt_r <= pulse_cnt_r + 8'h01;
    end
  end

  assign pulse_on = cal_mode || (pulse_cnt_r < `LPSC_PULSE_ON);

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // Reset to the pulled-up idle level so release is not seen as a short
      pin_meta_r <= `LPSC_PIN_IDLE;
      pin_sync_r <= `LPSC_PIN_IDLE;
    end else begin
      pin_meta_r <= LASER_DRIVE_PIN_IN;
      pin_sync_r <= pin_meta_r;
    end
  end

  lpsc_self_test u_self_test (
    .CORE_CLK     (CORE_CLK),
    .RST_N        (RST_N),
    .enable       (!fault_r),
    .pin_low_sync (!pin_sync_r),
    .test_active  (test_active),
    .test_fail    (test_fail)
  );

  // The sink is released one edge late and the synchronised pin lags two more,
  // so the low left behind by a self-test must not count as a short.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      test_hist_r <= '0;
    end else begin
      test_hist_r <= {test_hist_r[`LPSC_BLANK_LEN-2:0], test_active};
    end
  end

  assign test_blank = test_active || (|test_hist_r);

  // Pin low while we source current and are not sinking it is a ground path.
  // Only judged during a drive pulse with LASER_DRIVE_EN high; an idle pin sits at the pulled-up high level.
  assign ground_fault = pulse_on && !test_blank && !pin_sync_r && LASER_DRIVE_EN;

  assign fault_any = fault_r || ground_fault || test_fail;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fault_r <= 1'b0;
    end else if (ground_fault || test_fail) begin
      fault_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    drive_nxt.drive_en = pulse_on && !test_active && !fault_any;
    drive_nxt.range    = ctrl_second_r[`LPSC_RANGE_HI:`LPSC_RANGE_LO];
    drive_nxt.current  = cur_applied_r;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LASER_DRIVE_EN <= 1'b0;
      LASER_RANGE    <= 2'b00;
      LASER_CURRENT  <= `LPSC_CUR_MIN;
    end else begin
      LASER_DRIVE_EN <= drive_nxt.drive_en;
      LASER_RANGE    <= drive_nxt.range;
      LASER_CURRENT  <= fault_any ? `LPSC_CUR_MIN : drive_nxt.current;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LASER_DRIVE_PIN_OUT <= 1'b0;
      LASER_DRIVE_PIN_OE  <= 1'b0;
    end else begin
      LASER_DRIVE_PIN_OUT <= 1'b0;
      LASER_DRIVE_PIN_OE  <= test_active;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LASER_SUPPLY_SWITCH_N <= 1'b0;
      LASER_FAULT           <= 1'b0;
    end else begin
      LASER_SUPPLY_SWITCH_N <= fault_any || test_active;
      LASER_FAULT           <= fault_any;
    end
  end

endmodule // lpsc_top

// >>> inc/lpsc_defines.svh
`ifndef LPSC_DEFINES_SVH
`define LPSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LPSC_ADDR_CTRL_FIRST   7'h1a
`define LPSC_ADDR_CFG_FIRST    7'h1c
`define LPSC_ADDR_CFG_SECOND   7'h1d
`define LPSC_ADDR_CTRL_SECOND  7'h1f
`define LPSC_REG_RESET         8'h00
`define LPSC_CUR_MIN           8'h00

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define LPSC_RANGE_HI          7
`define LPSC_RANGE_LO          6
`define LPSC_CAL_HI            3
`define LPSC_CAL_LO            1
`define LPSC_CAL_ALL           3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LPSC_PULSE_PERIOD      8'h63
`define LPSC_PULSE_ON          8'h09
`define LPSC_TEST_PERIOD       16'h03e7
`define LPSC_TEST_SETTLE       16'h0004
`define LPSC_TEST_SAMPLE       16'h0007
`define LPSC_BLANK_LEN         3
`define LPSC_PIN_IDLE          1'b1

`endif

// >>> inc/lpsc_pkg.sv
package lpsc_pkg;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } lpsc_wr_t;

  typedef struct packed {
    logic       drive_en;
    logic [1:0] range;
    logic [7:0] current;
  } lpsc_drive_t;

  typedef enum logic [1:0] {
    LPSC_ST_IDLE   = 2'b00,
    LPSC_ST_SETTLE = 2'b01,
    LPSC_ST_SAMPLE = 2'b10
  } lpsc_test_st_t;

endpackage

// >>> rtl/lpsc_self_test.sv
`timescale 1ns/10ps
`include "lpsc_defines.svh"

module lpsc_self_test (
  input  wire logic CORE_CLK,
  input  wire logic RST_N,
  input  wire logic enable,
  input  wire logic pin_low_sync,
  output logic      test_active,
  output logic      test_fail
);

  lpsc_pkg::lpsc_test_st_t state_r;
  logic [15:0]             cnt_r;

  // ----------------------------------------------------------------
  // Periodic supply-short test
  // ----------------------------------------------------------------
  // sink pin, expect low
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= lpsc_pkg::LPSC_ST_IDLE;
      cnt_r   <= 16'h0000;
    end else begin
      case (state_r)
        lpsc_pkg::LPSC_ST_IDLE: begin
          if (!enable) begin
            cnt_r <= 16'h0000;
          end else if (cnt_r == `LPSC_TEST_PERIOD) begin
            cnt_r   <= 16'h0000;
            state_r <= lpsc_pkg::LPSC_ST_SETTLE;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        lpsc_pkg::LPSC_ST_SETTLE: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == `LPSC_TEST_SETTLE) begin
            state_r <= lpsc_pkg::LPSC_ST_SAMPLE;
          end
        end
        lpsc_pkg::LPSC_ST_SAMPLE: begin
          cnt_r   <= 16'h0000;
          state_r <= lpsc_pkg::LPSC_ST_IDLE;
        end
        default: begin
          state_r <= lpsc_pkg::LPSC_ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    test_active = (state_r != lpsc_pkg::LPSC_ST_IDLE);
    // Pin held high against our sink means a short to a supply
    test_fail   = (state_r == lpsc_pkg::LPSC_ST_SAMPLE) && !pin_low_sync;
  end

endmodule // lpsc_self_test

// >>> tb/lpsc_pin_model.sv
`timescale 1ns/10ps
module lpsc_pin_model (
  input  wire logic oe,
  input  wire logic short_sup,
  input  wire logic short_gnd,
  output logic      pin
);
  // A supply short beats the sink; a ground path beats the pull-up
  assign pin = oe ? short_sup : !short_gnd;
endmodule // lpsc_pin_model

// >>> tb/lpsc_chk.sv
`timescale 1ns/10ps
module lpsc_chk (
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       REG_WE,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       LASER_DRIVE_PIN_IN,
  input wire logic       LASER_DRIVE_PIN_OE,
  input wire logic       LASER_DRIVE_EN,
  input wire logic [7:0] LASER_CURRENT,
  input wire logic       LASER_SUPPLY_SWITCH_N,
  input wire logic       LASER_FAULT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic cal_r;
  logic cal_d_r;
  // Mirror of calibration mode, delayed so the drive has landed
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_r   <= 1'b0;
      cal_d_r <= 1'b0;
    end else begin
      if (REG_WE && REG_ADDR == 7'h1a) cal_r <= (REG_WDATA[3:1] == 3'h7);
      cal_d_r <= cal_r;
    end
  end
  property p_sw; LASER_FAULT |-> LASER_SUPPLY_SWITCH_N; endproperty
  a_sw: assert property (p_sw) else $error("switch low in fault");
  property p_off; LASER_FAULT |-> !LASER_DRIVE_EN && LASER_CURRENT == 8'h00; endproperty
  a_off: assert property (p_off) else $error("drive on in fault");
  property p_hold; LASER_FAULT |=> LASER_FAULT; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");
  property p_test; $rose(LASER_DRIVE_PIN_OE) |-> ##[0:2] LASER_SUPPLY_SWITCH_N; endproperty
  a_test: assert property (p_test) else $error("laser on in self test");
  property p_gnd;
    LASER_DRIVE_EN && !LASER_DRIVE_PIN_OE && !LASER_DRIVE_PIN_IN |-> ##[0:3] LASER_FAULT;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground path missed");
  property p_cw;
    cal_d_r && !LASER_FAULT |-> LASER_DRIVE_EN || LASER_SUPPLY_SWITCH_N
      || $past(LASER_SUPPLY_SWITCH_N);
  endproperty
  a_cw: assert property (p_cw) else $error("drive not continuous");
  logic [7:0] run_r;
  // Drive-enable cycles in a row before this one, saturating
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_r <= 8'h00;
    end else if (!LASER_DRIVE_EN) begin
      run_r <= 8'h00;
    end else if (run_r != 8'hff) begin
      run_r <= run_r + 8'h01;
    end
  end
  property p_pulse; LASER_DRIVE_EN && !cal_r && !cal_d_r |-> run_r < 8'h09; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_apply;
    $changed(LASER_CURRENT) |-> LASER_CURRENT == 8'h00 || $past(REG_WE)
      || $past(REG_WE, 2) || $past(REG_WE, 3);
  endproperty
  a_apply: assert property (p_apply) else $error("current moved unbidden");
  c_fault: cover property ($rose(LASER_FAULT));
  c_test: cover property ($rose(LASER_DRIVE_PIN_OE));
  c_cw: cover property (cal_d_r && LASER_DRIVE_EN[*8]);
endmodule // lpsc_chk
bind lpsc_top lpsc_chk u_chk (.CORE_CLK, .RST_N, .REG_WE, .REG_ADDR, .REG_WDATA,
  .LASER_DRIVE_PIN_IN, .LASER_DRIVE_PIN_OE, .LASER_DRIVE_EN, .LASER_CURRENT,
  .LASER_SUPPLY_SWITCH_N, .LASER_FAULT);

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic       clk, rst_n, we, pin, oe, den, sw_n, flt, s_sup, s_gnd, seen;
  logic       pout, sink;
  logic [6:0] raddr [5];
  logic [6:0] addr;
  logic [7:0] wd, rdat, cur, rv;
  logic [1:0] rng;
  int         bad_count, comparisons, mx, r;
  lpsc_top dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_WE(we), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_RDATA(rdat), .LASER_DRIVE_PIN_IN(pin),
    .LASER_DRIVE_PIN_OUT(pout), .LASER_DRIVE_PIN_OE(oe), .LASER_DRIVE_EN(den),
    .LASER_RANGE(rng), .LASER_CURRENT(cur), .LASER_SUPPLY_SWITCH_N(sw_n),
    .LASER_FAULT(flt));
  lpsc_pin_model u_pin (.oe(oe), .short_sup(s_sup), .short_gnd(s_gnd), .pin(pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    we = 1'b1;
    addr = a;
    wd = d;
    step(1);
  endtask
  task automatic idle();
    we = 1'b0;
    step(3);
  endtask
  task automatic rd(logic [6:0] a);
    addr = a;
    step(1);
    rv = rdat;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic waitf(int n);
    for (int i = 0; i < n && flt !== 1'b1; i++) step(1);
    if (flt !== 1'b1) begin
      bad_count++;
      $display("[FAIL] fault wait exp 1 got 0");
      results();
    end
  endtask
  task automatic run(int n);
    mx = 0;
    r = 0;
    repeat (n) begin
      step(1);
      r = (den === 1'b1) ? r + 1 : 0;
      if (r > mx) mx = r;
    end
  endtask
  initial begin
    {bad_count, comparisons, we, s_sup, s_gnd, seen, sink, rst_n} = '0;
    raddr = '{7'h1a, 7'h1c, 7'h1d, 7'h1f, 7'h33};
    addr = 7'h00;
    wd = 8'h00;
    step(2);
    rst_n = 1'b1;
    foreach (raddr[i]) begin
      rd(raddr[i]);
      chk("reset read", 8'h00, rv);
    end
    chk("switch", 8'h00, {7'h00, sw_n});
    wr(7'h1f, 8'h40);
    wr(7'h1c, 8'h05);
    wr(7'h1d, 8'hfa);
    idle();
    chk("current", 8'h05, cur);
    rd(7'h1f);
    chk("ctrl second", 8'h40, rv);
    chk("range", 8'h01, {6'h00, rng});
    wr(7'h1c, 8'h07);
    idle();
    chk("mismatch", 8'h05, cur);
    wr(7'h1d, 8'hf8);
    idle();
    chk("late pair", 8'h07, cur);
    wr(7'h1c, 8'h00);
    wr(7'h1d, 8'hff);
    idle();
    chk("minimum", 8'h00, cur);
    wr(7'h1f, 8'h80);
    wr(7'h1c, 8'h05);
    wr(7'h1d, 8'hfa);
    idle();
    chk("high range", 8'h02, {6'h00, rng});
    run(300);
    chk("pulse", 8'h09, mx[7:0]);
    wr(7'h1a, 8'h0e);
    idle();
    rd(7'h1a);
    chk("ctrl first", 8'h0e, rv);
    run(150);
    chk("continuous", 8'h01, {7'h00, mx > 9});
    repeat (2100) begin
      step(1);
      if (oe === 1'b1) seen = 1'b1;
      if (oe === 1'b1 && pout !== 1'b0) sink = 1'b1;
    end
    chk("self test", 8'h01, {7'h00, seen});
    chk("sink level", 8'h00, {7'h00, sink});
    chk("no fault", 8'h00, {7'h00, flt});
    s_sup = 1'b1;
    waitf(1100);
    chk("switch", 8'h01, {7'h00, sw_n});
    chk("cut", 8'h00, {7'h00, den} | cur);
    s_sup = 1'b0;
    step(50);
    rd(7'h1a);
    chk("latched", 8'h01, {7'h00, rv[0] & flt});
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    chk("cleared", 8'h00, {7'h00, flt});
    wr(7'h1f, 8'h80);
    wr(7'h1c, 8'h05);
    wr(7'h1d, 8'hfa);
    wr(7'h1a, 8'h0e);
    idle();
    rd(7'h1c);
    chk("restored", 8'h05, rv);
    run(20);
    chk("recheck drive", 8'h01, {7'h00, mx > 9});
    s_gnd = 1'b1;
    waitf(200);
    chk("gnd switch", 8'h01, {7'h00, sw_n});
    results();
  end
endmodule // testbench
